// ### mqf_top.sv
// Multi-queue FIFO with shared write/read ports, flag busses and APB setup
//
// Overview of operation
// - Between one and thirty-two independent queues share one write and one read port.
// - Write and read queue selects act independently, even on the same queue.
// - Full shows for the write-selected queue, output-valid for the read-selected one.
// - Every queue has its own almost-full and almost-empty threshold and flags.
// - Two eight-bit busses carry almost-full and almost-empty flags of many queues.
// - Up to eight queues map one bit each; more use polled or direct mode.
// - Write and read widths are 9 or 18 bits each, global for all queues.
// - Width conversion is little endian: the earlier narrow word is the low half.
// - Each queue owns a fixed block of eight 9-bit words, whatever the queue count.
// - Queue count and thresholds load only through the programming port.
// - Without programming, thirty-two equal-depth queues are used.
// - Master reset captures the width selects; programming follows master reset.
// - Partial reset clears one queue, which must be selected on both ports.
// - The read port registers the next word one clock after an accepted read request.
// - One write and one read can complete on every clock.
// - Polled busses step one quadrant per edge of the one shared clock.
// - Quadrants hold queues 1-8, 9-16, 17-24, 25-32; unused bits are don't-care.
// - In direct mode each port selects its own bus quadrant.
// - Switching to an empty queue keeps the last output word.
`timescale 1ns/1ns
module mqf_top
  import mqf_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 wide_in_sel,
  input  wire logic                 wide_out_sel,
  input  wire logic                 wr_en,
  input  wire logic [QSEL_W-1:0]    write_queue_select,
  input  wire logic [DATA_W-1:0]    wr_data,
  input  wire logic [QUAD_W-1:0]    af_quad_sel,
  input  wire logic                 rd_en,
  input  wire logic [QSEL_W-1:0]    read_queue_select,
  input  wire logic [QUAD_W-1:0]    ae_quad_sel,
  input  wire logic                 queue_pointer_clear,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  output logic      [DATA_W-1:0]    rd_data,
  output logic                      output_valid_flag,
  output logic                      queue_full_flag,
  output logic                      almost_full_flag,
  output logic                      almost_empty_flag,
  output logic      [QUAD_Q-1:0]    af_bus,
  output logic      [QUAD_W-1:0]    af_bus_quad,
  output logic      [QUAD_Q-1:0]    ae_bus,
  output logic      [QUAD_W-1:0]    ae_bus_quad
);

  logic [1:0]          rst_sync_q;
  logic                rst_n;
  mqf_state_type       s_q;
  mqf_state_type       s_d;

  logic [NUM_Q-1:0]              q_push;
  logic [NUM_Q-1:0]              q_pop;
  logic [NUM_Q-1:0]              q_clear;
  logic [NUM_Q-1:0][CNT_W-1:0]   q_count;
  logic [NUM_Q-1:0][DATA_W-1:0]  q_head;
  logic [NUM_Q-1:0]              q_af;
  logic [NUM_Q-1:0]              q_ae;
  logic [NUM_Q-1:0]              q_in_use;

  logic                wsel_ok;
  logic                rsel_ok;
  logic [CNT_W-1:0]    w_need;
  logic [CNT_W-1:0]    r_need;
  logic [CNT_W-1:0]    w_cnt;
  logic [CNT_W-1:0]    r_cnt;
  logic                wr_ok;
  logic                rd_ok;
  logic                part_clear;
  logic                master_apply;
  logic                apb_write;
  logic                setup_phase;
  logic                hit_ctrl;
  logic                hit_status;
  logic                hit_thresh;
  logic [QSEL_W-1:0]   thr_idx;
  logic [QCNT_W-1:0]   new_qcount;
  logic [DATA_W-1:0]   rd_word;
  logic [QUAD_W-1:0]   af_q_use;
  logic [QUAD_W-1:0]   ae_q_use;
  logic [LVL_W-1:0]    ae_wr;
  logic [LVL_W-1:0]    af_wr;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_sync_q <= 2'h0;
    end
    else
    begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_Q; gi++)
    begin : g_queue
      mqf_queue u_queue (
        .clk          (clk),
        .rst_n        (rst_n),
        .clear        (q_clear[gi]),
        .push         (q_push[gi]),
        .push_two     (s_q.wide_in),
        .push_data    (wr_data),
        .pop          (q_pop[gi]),
        .pop_two      (s_q.wide_out),
        .af_level     (s_q.af_lvl[gi]),
        .ae_level     (s_q.ae_lvl[gi]),
        .count        (q_count[gi]),
        .head         (q_head[gi]),
        .almost_full  (q_af[gi]),
        .almost_empty (q_ae[gi])
      );
      assign q_in_use[gi] = QCNT_W'(gi) < s_q.qcount;
    end
  endgenerate

  always_comb
  begin
    s_d = s_q;

    // APB decode; a one-cycle setup gives a registered answer in access
    setup_phase  = psel && !penable;
    apb_write    = psel && penable && pwrite && s_q.pready;
    hit_ctrl     = paddr == CTRL_OFFSET;
    hit_status   = paddr == STATUS_OFFSET;
    hit_thresh   = (paddr[11:THRESH_PAGE_LSB] == THRESH_PAGE) && (paddr[1:0] == 2'h0);
    thr_idx      = paddr[THRESH_PAGE_LSB-1:2];
    new_qcount   = pwdata[CTRL_QCOUNT_LSB +: QCNT_W];
    master_apply = apb_write && hit_ctrl && pwdata[CTRL_APPLY_BIT];

    // Port widths set words per access in byte units
    w_need  = s_q.wide_in ? 4'h2 : 4'h1;
    r_need  = s_q.wide_out ? 4'h2 : 4'h1;
    wsel_ok = q_in_use[write_queue_select];
    rsel_ok = q_in_use[read_queue_select];
    w_cnt   = q_count[write_queue_select];
    r_cnt   = q_count[read_queue_select];

    // Partial reset only counts when both ports select the same queue
    part_clear = queue_pointer_clear && (write_queue_select == read_queue_select);

    wr_ok = wr_en && wsel_ok && ((DEPTH_CNT - w_cnt) >= w_need) && !master_apply
            && !part_clear;
    rd_ok = rd_en && rsel_ok && (r_cnt >= r_need) && !master_apply && !part_clear;

    q_push  = '0;
    q_pop   = '0;
    q_clear = '0;
    if (master_apply)
    begin
      q_clear = '1;
    end
    else if (part_clear)
    begin
      q_clear[write_queue_select] = 1'b1;
    end
    q_push[write_queue_select] = wr_ok;
    q_pop[read_queue_select]   = rd_ok;

    // Straps taken on the first edge after release and on master apply
    if (!s_q.strap_done || master_apply)
    begin
      s_d.strap_done = 1'b1;
      s_d.wide_in    = wide_in_sel;
      s_d.wide_out   = wide_out_sel;
    end

    // Read side: narrow output takes the low byte only, upper bits zero
    if (s_q.wide_out)
    begin
      rd_word = q_head[read_queue_select];
    end
    else
    begin
      rd_word = {{BYTE_W{1'b0}}, q_head[read_queue_select][BYTE_W-1:0]};
    end
    s_d.out_valid = rd_ok;
    if (rd_ok)
    begin
      s_d.rd_data = rd_word;
    end
    else
    begin
      // An empty or unconfigured queue leaves the prior word visible
      s_d.rd_data = s_q.rd_data;
    end

    if (rsel_ok)
    begin
      s_d.aempty = q_ae[read_queue_select];
    end
    else
    begin
      s_d.aempty = 1'b1;
    end

    // Write-side flags; an unconfigured queue reads as full so producers hold off
    if (wsel_ok)
    begin
      s_d.full  = (DEPTH_CNT - w_cnt) < w_need;
      s_d.afull = q_af[write_queue_select];
    end
    else
    begin
      s_d.full  = 1'b1;
      s_d.afull = 1'b1;
    end

    // Flag busses; a single quadrant needs no stepping
    s_d.af_poll = s_q.af_poll + 2'h1;
    s_d.ae_poll = s_q.ae_poll + 2'h1;
    if (s_q.qcount <= QCOUNT_ONEQUAD)
    begin
      af_q_use = 2'h0;
      ae_q_use = 2'h0;
    end
    else if (s_q.flag_direct)
    begin
      af_q_use = af_quad_sel;
      ae_q_use = ae_quad_sel;
    end
    else
    begin
      af_q_use = s_q.af_poll;
      ae_q_use = s_q.ae_poll;
    end
    s_d.af_quad = af_q_use;
    s_d.ae_quad = ae_q_use;
    for (int i = 0; i < QUAD_Q; i++)
    begin
      // Bits past the configured count are driven low
      s_d.af_bus[i] = q_af[{af_q_use, 3'(i)}] && q_in_use[{af_q_use, 3'(i)}];
      s_d.ae_bus[i] = q_ae[{ae_q_use, 3'(i)}] && q_in_use[{ae_q_use, 3'(i)}];
    end

    // Register writes; the setup port stands in for serial programming
    if (apb_write && hit_ctrl)
    begin
      s_d.flag_direct = pwdata[CTRL_DIRECT_BIT];
      if (master_apply)
      begin
        // Zero or oversize counts fall back to the full layout
        if ((new_qcount == 6'h0) || (new_qcount > QCOUNT_MAX))
        begin
          s_d.qcount = QCOUNT_DEFAULT;
        end
        else
        begin
          s_d.qcount = new_qcount;
        end
      end
    end
    // Levels past the queue depth would wrap the compares, so they saturate
    ae_wr = pwdata[THR_AE_LSB +: LVL_W];
    af_wr = pwdata[THR_AF_LSB +: LVL_W];
    if (ae_wr > DEPTH_CNT)
    begin
      ae_wr = DEPTH_CNT;
    end
    if (af_wr > DEPTH_CNT)
    begin
      af_wr = DEPTH_CNT;
    end
    if (apb_write && hit_thresh)
    begin
      s_d.ae_lvl[thr_idx] = ae_wr;
      s_d.af_lvl[thr_idx] = af_wr;
    end

    // Read data prepared in setup so every APB output is a flop
    s_d.pready  = setup_phase;
    s_d.pslverr = setup_phase && !(hit_ctrl || hit_status || hit_thresh);
    s_d.prdata  = 32'h0;
    if (setup_phase && !pwrite)
    begin
      if (hit_ctrl)
      begin
        s_d.prdata[CTRL_QCOUNT_LSB +: QCNT_W] = s_q.qcount;
        s_d.prdata[CTRL_DIRECT_BIT]          = s_q.flag_direct;
      end
      else if (hit_status)
      begin
        s_d.prdata[STAT_WIN_BIT]              = s_q.wide_in;
        s_d.prdata[STAT_WOUT_BIT]             = s_q.wide_out;
        s_d.prdata[STAT_WCNT_LSB +: CNT_W]    = w_cnt;
        s_d.prdata[STAT_RCNT_LSB +: CNT_W]    = r_cnt;
      end
      else if (hit_thresh)
      begin
        s_d.prdata[THR_AE_LSB +: LVL_W] = s_q.ae_lvl[thr_idx];
        s_d.prdata[THR_AF_LSB +: LVL_W] = s_q.af_lvl[thr_idx];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q            <= '0;
      s_q.qcount     <= QCOUNT_DEFAULT;
      s_q.ae_lvl     <= {NUM_Q{AE_LVL_DEFAULT}};
      s_q.af_lvl     <= {NUM_Q{AF_LVL_DEFAULT}};
      s_q.full       <= 1'b1;
      s_q.afull      <= 1'b1;
      s_q.aempty     <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign prdata            = s_q.prdata;
  assign pready            = s_q.pready;
  assign pslverr           = s_q.pslverr;
  assign rd_data           = s_q.rd_data;
  assign output_valid_flag = s_q.out_valid;
  assign queue_full_flag   = s_q.full;
  assign almost_full_flag  = s_q.afull;
  assign almost_empty_flag = s_q.aempty;
  assign af_bus            = s_q.af_bus;
  assign af_bus_quad       = s_q.af_quad;
  assign ae_bus            = s_q.ae_bus;
  assign ae_bus_quad       = s_q.ae_quad;

endmodule : mqf_top

// ### mqf_pkg.sv
// Shared constants and types for the multi-queue FIFO
package mqf_pkg;

  localparam int unsigned NUM_Q         = 32;
  localparam int unsigned QUAD_Q        = 8;
  localparam int unsigned QUAD_W        = 2;
  localparam int unsigned QSEL_W        = 5;
  localparam int unsigned QCNT_W        = 6;
  localparam int unsigned DATA_W        = 18;
  localparam int unsigned BYTE_W        = 9;
  localparam int unsigned DEPTH         = 8;
  localparam int unsigned PTR_W         = 3;
  localparam int unsigned CNT_W         = 4;
  localparam int unsigned LVL_W         = 4;
  localparam int unsigned BLOCK_WORDS_X18 = 512;
  localparam int unsigned BLOCK_WORDS_X9  = 1024;

  localparam logic [CNT_W-1:0]  DEPTH_CNT       = 4'h8;
  localparam logic [QCNT_W-1:0] QCOUNT_DEFAULT  = 6'h20;
  localparam logic [QCNT_W-1:0] QCOUNT_MAX      = 6'h20;
  localparam logic [QCNT_W-1:0] QCOUNT_ONEQUAD  = 6'h08;
  localparam logic [LVL_W-1:0]  AE_LVL_DEFAULT  = 4'h1;
  localparam logic [LVL_W-1:0]  AF_LVL_DEFAULT  = 4'h1;

  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [4:0]  THRESH_PAGE   = 5'h01;
  localparam int unsigned THRESH_PAGE_LSB = 7;

  localparam int unsigned CTRL_QCOUNT_LSB = 0;
  localparam int unsigned CTRL_DIRECT_BIT = 8;
  localparam int unsigned CTRL_APPLY_BIT  = 31;
  localparam int unsigned STAT_WIN_BIT    = 0;
  localparam int unsigned STAT_WOUT_BIT   = 1;
  localparam int unsigned STAT_WCNT_LSB   = 8;
  localparam int unsigned STAT_RCNT_LSB   = 16;
  localparam int unsigned THR_AE_LSB      = 0;
  localparam int unsigned THR_AF_LSB      = 8;

  typedef struct packed {
    logic [DEPTH-1:0][BYTE_W-1:0] mem;
    logic [PTR_W-1:0]             wptr;
    logic [PTR_W-1:0]             rptr;
    logic [CNT_W-1:0]             cnt;
  } mqf_queue_type;

  typedef struct packed {
    logic                         strap_done;
    logic                         wide_in;
    logic                         wide_out;
    logic [QCNT_W-1:0]            qcount;
    logic                         flag_direct;
    logic [NUM_Q-1:0][LVL_W-1:0]  ae_lvl;
    logic [NUM_Q-1:0][LVL_W-1:0]  af_lvl;
    logic [DATA_W-1:0]            rd_data;
    logic                         out_valid;
    logic                         full;
    logic                         afull;
    logic                         aempty;
    logic [QUAD_Q-1:0]            af_bus;
    logic [QUAD_Q-1:0]            ae_bus;
    logic [QUAD_W-1:0]            af_quad;
    logic [QUAD_W-1:0]            ae_quad;
    logic [QUAD_W-1:0]            af_poll;
    logic [QUAD_W-1:0]            ae_poll;
    logic [31:0]                  prdata;
    logic                         pready;
    logic                         pslverr;
  } mqf_state_type;

endpackage : mqf_pkg

// ### mqf_queue.sv
// One byte-organised queue with its pointers and level flags
`timescale 1ns/1ns
module mqf_queue
  import mqf_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 clear,
  input  wire logic                 push,
  input  wire logic                 push_two,
  input  wire logic [DATA_W-1:0]    push_data,
  input  wire logic                 pop,
  input  wire logic                 pop_two,
  input  wire logic [LVL_W-1:0]     af_level,
  input  wire logic [LVL_W-1:0]     ae_level,
  output logic      [CNT_W-1:0]     count,
  output logic      [DATA_W-1:0]    head,
  output logic                      almost_full,
  output logic                      almost_empty
);

  mqf_queue_type q_q;
  mqf_queue_type q_d;
  logic [CNT_W-1:0] push_n;
  logic [CNT_W-1:0] pop_n;

  always_comb
  begin
    q_d    = q_q;
    push_n = push ? (push_two ? 4'h2 : 4'h1) : 4'h0;
    pop_n  = pop ? (pop_two ? 4'h2 : 4'h1) : 4'h0;
    if (clear)
    begin
      // Only pointers and count reset; stale data is harmless
      q_d.wptr = 3'h0;
      q_d.rptr = 3'h0;
      q_d.cnt  = 4'h0;
    end
    else
    begin
      if (push)
      begin
        q_d.mem[q_q.wptr] = push_data[BYTE_W-1:0];
        if (push_two)
        begin
          q_d.mem[q_q.wptr + 3'h1] = push_data[DATA_W-1:BYTE_W];
        end
        q_d.wptr = q_q.wptr + push_n[PTR_W-1:0];
      end
      if (pop)
      begin
        q_d.rptr = q_q.rptr + pop_n[PTR_W-1:0];
      end
      q_d.cnt = q_q.cnt + push_n - pop_n;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q_q <= '0;
    end
    else
    begin
      q_q <= q_d;
    end
  end

  assign count        = q_q.cnt;
  assign head         = {q_q.mem[q_q.rptr + 3'h1], q_q.mem[q_q.rptr]};
  assign almost_full  = q_q.cnt >= (DEPTH_CNT - af_level);
  assign almost_empty = q_q.cnt <= ae_level;

endmodule : mqf_queue

// ### mqf_props.sv
// Timing checker for the multi-queue FIFO ports
`timescale 1ns/1ns
module mqf_props
  import mqf_pkg::*;
(
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic              rd_en,
  input wire logic [QSEL_W-1:0] write_queue_select,
  input wire logic [QUAD_W-1:0] af_quad_sel,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic              output_valid_flag,
  input wire logic              queue_full_flag,
  input wire logic [QUAD_W-1:0] af_bus_quad,
  input wire logic [QUAD_W-1:0] ae_bus_quad
);
  logic [1:0]        quiet_q;
  logic              direct_q;
  logic [QCNT_W-1:0] qc_q;
  logic              ctrl_wr;
  logic              mapped;
  logic              settled;
  logic              many;
  assign ctrl_wr = psel && penable && pready && pwrite && paddr == CTRL_OFFSET;
  assign mapped  = paddr == CTRL_OFFSET || paddr == STATUS_OFFSET || (paddr[11:7] == THRESH_PAGE && paddr[1:0] == 2'h0);
  assign settled = quiet_q == 2'h3 && !ctrl_wr;
  assign many    = qc_q > QCOUNT_ONEQUAD;
  // Apply clears all queues, so flags get a few edges before they are judged
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      quiet_q  <= 2'h0;
      direct_q <= 1'b0;
      qc_q     <= QCOUNT_DEFAULT;
    end
    else if (ctrl_wr)
    begin
      quiet_q  <= 2'h0;
      direct_q <= pwdata[CTRL_DIRECT_BIT];
      if (pwdata[CTRL_APPLY_BIT])
        qc_q <= (pwdata[5:0] == 6'h0 || pwdata[5:0] > QCOUNT_MAX) ? QCOUNT_MAX : pwdata[5:0];
    end
    else if (quiet_q != 2'h3)
      quiet_q <= quiet_q + 2'h1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("APB answer not one cycle");
  a_bad_addr: assert property (pready |-> pslverr == !mapped && (mapped || prdata == 32'h0))
    else $error("APB error response wrong");
  a_valid_cause: assert property (output_valid_flag |-> $past(rd_en))
    else $error("Output valid without read");
  a_data_hold: assert property (settled && !rd_en |=> $stable(rd_data))
    else $error("Read data moved without read");
  a_poll_af: assert property (settled && many && !direct_q |=> af_bus_quad == $past(af_bus_quad) + 2'h1)
    else $error("Almost-full quadrant did not step");
  a_poll_ae: assert property (settled && many && !direct_q |=> ae_bus_quad == $past(ae_bus_quad) + 2'h1)
    else $error("Almost-empty quadrant did not step");
  a_direct_af: assert property (settled && many && direct_q && $stable(af_quad_sel) ##1
    settled && $stable(af_quad_sel) |=> af_bus_quad == $past(af_quad_sel))
    else $error("Direct quadrant not followed");
  a_one_quad: assert property (settled && !many |-> af_bus_quad == 2'h0 && ae_bus_quad == 2'h0)
    else $error("Quadrant moved with few queues");
  a_unconf_full: assert property (settled && {1'b0, write_queue_select} >= qc_q |=> queue_full_flag)
    else $error("Unconfigured queue not full");
  c_read: cover property (output_valid_flag);
  c_refuse: cover property (pready && pslverr);
  c_direct: cover property (direct_q && af_bus_quad == 2'h2);
endmodule : mqf_props
bind mqf_top mqf_props u_props (.clk, .reset_n, .rd_en, .write_queue_select, .af_quad_sel, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rd_data, .output_valid_flag, .queue_full_flag,
  .af_bus_quad, .ae_bus_quad);

// ### mqf_prod.sv
// Producer model on the write port, prompt or slow
`timescale 1ns/1ns
module mqf_prod
  import mqf_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              slow,
  output logic                   wr_en,
  output logic      [QSEL_W-1:0] write_queue_select,
  output logic      [DATA_W-1:0] wr_data
);
  logic [QSEL_W+DATA_W-1:0] jobs[$];
  logic                     gap = 1'b0;
  initial
  begin
    {wr_en, write_queue_select, wr_data} = '0;
  end
  task push(input logic [QSEL_W-1:0] q, input logic [DATA_W-1:0] d);
    jobs.push_back({q, d});
  endtask : push
  // Idle data toggles so a stale word never looks like a fresh one
  always @(posedge clk)
    if (jobs.size() > 0 && !(slow && gap))
    begin
      {write_queue_select, wr_data} <= jobs.pop_front();
      wr_en <= 1'b1;
      gap   <= 1'b1;
    end
    else
    begin
      wr_en   <= 1'b0;
      wr_data <= ~wr_data;
      gap     <= 1'b0;
    end
endmodule : mqf_prod

// ### mqf_top_tb.sv
// Self-checking bench for the multi-queue FIFO
`timescale 1ns/1ns
module mqf_top_tb
  import mqf_pkg::*;
;
  logic              clk, reset_n, wide_in_sel, wide_out_sel, rd_en, queue_pointer_clear, slow;
  logic              psel, penable, pwrite, pready, pslverr, wr_en, output_valid_flag;
  logic              queue_full_flag, almost_full_flag, almost_empty_flag;
  logic [QSEL_W-1:0] write_queue_select, read_queue_select;
  logic [QUAD_W-1:0] af_quad_sel, ae_quad_sel, af_bus_quad, ae_bus_quad;
  logic [DATA_W-1:0] wr_data, rd_data;
  logic [QUAD_Q-1:0] af_bus, ae_bus;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata;
  logic [DATA_W-1:0] expq[$];
  logic [DATA_W-1:0] w[6];
  integer            bad_count = 0, n_tests = 0, seed = 32'h837675b1;
  mqf_top DUT (.clk, .reset_n, .wide_in_sel, .wide_out_sel, .wr_en, .write_queue_select, .wr_data,
    .af_quad_sel, .rd_en, .read_queue_select, .ae_quad_sel, .queue_pointer_clear, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rd_data, .output_valid_flag, .queue_full_flag,
    .almost_full_flag, .almost_empty_flag, .af_bus, .af_bus_quad, .ae_bus, .ae_bus_quad);
  mqf_prod u_prod (.clk, .slow, .wr_en, .write_queue_select, .wr_data);
  task chk(input logic [39:0] g, e);
    n_tests++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, e, input logic err);
    int k;
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    chk({pready, pslverr, wr ? 32'h0 : prdata}, {1'b1, err, wr ? 32'h0 : e});
    {psel, penable} <= 2'b00;
    @(posedge clk);
  endtask : apb
  task rd(input logic [QSEL_W-1:0] q, input logic v, input logic [DATA_W-1:0] e);
    {rd_en, read_queue_select} <= {1'b1, q};
    if (v)
      expq.push_back(e);
    @(posedge clk);
  endtask : rd
  task drain;
    while (u_prod.jobs.size() > 0)
      @(posedge clk);
    repeat (2) @(posedge clk);
  endtask : drain
  task wrap_up;
    $display("TB: counts bad=%0d tests=%0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  // Read words are judged one edge after they are presented
  always @(posedge clk)
    if (output_valid_flag === 1'b1)
      chk(rd_data, expq.size() > 0 ? expq.pop_front() : 32'hx);
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    #400000;
    bad_count++;
    wrap_up;
  end
  initial
  begin
    {reset_n, rd_en, queue_pointer_clear, psel, penable, pwrite, slow} = '0;
    {wide_in_sel, wide_out_sel, read_queue_select, af_quad_sel, ae_quad_sel, paddr, pwdata} = {2'h3, 53'h0};
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge clk);
    apb(0, CTRL_OFFSET, 0, 32'h20, 0);
    apb(0, STATUS_OFFSET, 0, 32'h3, 0);
    apb(0, 12'h040, 0, 0, 1);
    apb(1, 12'h084, 32'h103, 0, 0);
    apb(0, 12'h084, 0, 32'h103, 0);
    apb(0, 12'h080, 0, 32'h101, 0);
    slow <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      w[i] = $random(seed);
      u_prod.push(5'd2, w[i]);
    end
    drain;
    chk({queue_full_flag, almost_full_flag}, 2'b11);
    for (int i = 0; i < 5; i++)
      rd(5'd2, i < 4, w[i]);
    rd_en <= 1'b0;
    repeat (3) @(posedge clk);
    chk({almost_empty_flag, rd_data}, {1'b1, w[3]});
    slow <= 1'b0;
    for (int i = 0; i < 6; i++)
      w[i] = $random(seed);
    for (int i = 0; i < 3; i++)
      u_prod.push(5'd7, w[i]);
    drain;
    for (int i = 3; i < 6; i++)
      u_prod.push(5'd7, w[i]);
    for (int i = 0; i < 6; i++)
      rd(5'd7, 1, w[i]);
    rd_en <= 1'b0;
    u_prod.push(5'd9, w[0]);
    u_prod.push(5'd9, w[1]);
    drain;
    {read_queue_select, queue_pointer_clear} <= {5'd9, 1'b1};
    @(posedge clk);
    queue_pointer_clear <= 1'b0;
    rd(5'd9, 0, 0);
    u_prod.push(5'd10, w[2]);
    drain;
    queue_pointer_clear <= 1'b1;
    @(posedge clk);
    queue_pointer_clear <= 1'b0;
    rd(5'd10, 1, w[2]);
    // All four width pairs; bytes must come out in write order
    for (int m = 0; m < 4; m++)
    begin
      {rd_en, wide_in_sel, wide_out_sel} <= {1'b0, m[1], m[0]};
      @(posedge clk);
      apb(1, CTRL_OFFSET, 32'h8000_0020, 0, 0);
      apb(0, STATUS_OFFSET, 0, {m[0], m[1]}, 0);
      w[0] = $random(seed);
      u_prod.push(5'd4, w[0]);
      if (!m[1])
        u_prod.push(5'd4, {w[0][8:0], w[0][17:9]});
      drain;
      if (m[0])
        rd(5'd4, 1, w[0]);
      else
      begin
        rd(5'd4, 1, {9'h0, w[0][8:0]});
        rd(5'd4, 1, {9'h0, w[0][17:9]});
      end
    end
    rd_en <= 1'b0;
    for (int i = 0; i < 4; i++)
      u_prod.push(5'd17, w[i]);
    drain;
    chk({queue_full_flag, almost_full_flag}, 2'b11);
    apb(1, CTRL_OFFSET, 32'h120, 0, 0);
    {af_quad_sel, ae_quad_sel} <= 4'hb;
    repeat (4) @(posedge clk);
    chk({af_bus_quad, ae_bus_quad, af_bus, ae_bus}, {4'hb, 16'h02ff});
    apb(1, CTRL_OFFSET, 32'h20, 0, 0);
    repeat (8) @(posedge clk);
    apb(1, CTRL_OFFSET, 32'h8000_0004, 0, 0);
    apb(0, CTRL_OFFSET, 0, 32'h4, 0);
    repeat (3) @(posedge clk);
    chk({ae_bus_quad, ae_bus}, {2'h0, 8'h0f});
    u_prod.push(5'd10, w[1]);
    drain;
    chk(queue_full_flag, 1);
    rd(5'd10, 0, 0);
    rd_en <= 1'b0;
    apb(1, CTRL_OFFSET, 32'h8000_0000, 0, 0);
    apb(0, CTRL_OFFSET, 0, 32'h20, 0);
    chk(expq.size(), 0);
    wrap_up;
  end
endmodule : mqf_top_tb
